// ===== adc_channel_mode_control.sv
// Behaviour
// R1 - Low power_down_n puts device in power-down until released.
// R2 - Host drives power_down_n low when idle and no conversion needed.
// R3 - Power-down during conversion aborts it and floats serial output.
// R4 - Leave power-down on release high, ready after wake-up interval.
// R5 - Normal mode: first sample after wake invalid; selections apply one sample later.
// R6 - Low-power mode: first sample after wake valid, uses latched selections.
// R7 - Undriven power_down_n reads high through pull-up.
// R8 - Bypass high routes multiplexer straight to converter, skipping gain stage.
// R9 - Bypass high ignores gain selects; low restores their control.
// R10 - low_power_select high gives low-power mode, low gives normal.
// R11 - Undriven low_power_select reads low through pull-down.
// R12 - Sequencer enable high starts sequencing at next convert-start rise.
// R13 - Sequencer selects channel 0 first, advancing one per rise to 7.
// R14 - Sequencer wraps 7 to 0 while enable stays high.
// R15 - Sequencer enable high ignores channel-select inputs.
// R16 - Sequencing off selects channel equal to the 3-bit select value.
// R17 - Fall of convert-start starts conversion; output driven only while low.
// R18 - Gain codes decode to 1,2,3,4,6,8,12,16; bypass forces 1.
// R19 - Channel and gain selects latch on convert-start rise.
// R20 - Each rise of sequencer enable restarts sequence at channel 0; code advances from last channel if a convert-start rise shares its cycle.
// R21 - Power-down ignores convert-start edges; no conversion, no advance.
module adc_channel_mode_control #(
  parameter int CONV_CYCLES = 20
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic power_down_n_i,
  input wire logic power_down_n_driven_i,
  input wire logic low_power_select_i,
  input wire logic low_power_select_driven_i,
  input wire logic gain_stage_bypass_i,
  input wire logic seq_enable_i,
  input wire logic chan_sel_msb_i,
  input wire logic chan_sel_mid_i,
  input wire logic chan_sel_lsb_i,
  input wire logic gain_sel_msb_i,
  input wire logic gain_sel_mid_i,
  input wire logic gain_sel_lsb_i,
  input wire logic convert_start_bar_i,
  input wire logic result_bit_i,
  output logic powered_down_o,
  output logic ready_o,
  output logic low_power_mode_o,
  output logic gain_stage_bypass_o,
  output logic busy_o,
  output logic conv_start_o,
  output logic conv_abort_o,
  output logic sample_valid_o,
  output logic [adc_ctrl_pkg::CHAN_W-1:0] active_chan_o,
  output logic [adc_ctrl_pkg::GAIN_W-1:0] active_gain_o,
  output logic serial_result_out_o,
  output logic serial_result_out_oe_o
);

  // ***************************************************
  // Pin synchronisers
  // ***************************************************
  localparam int NPIN = 14;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s;
  logic pd_n_s, pd_drv_s, lp_s, lp_drv_s, byp_s, seq_s, csb_s, res_s;
  logic [2:0] chan_pins, gain_pins;

  assign pin_raw = {power_down_n_i, power_down_n_driven_i, low_power_select_i,
                    low_power_select_driven_i, gain_stage_bypass_i, seq_enable_i,
                    chan_sel_msb_i, chan_sel_mid_i, chan_sel_lsb_i,
                    gain_sel_msb_i, gain_sel_mid_i, gain_sel_lsb_i,
                    convert_start_bar_i, result_bit_i};

  pin_sync #(
    .WIDTH(NPIN)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(pin_raw),
    .reset_val_i(14'h2000),
    .sync_o(pin_s)
  );

  assign {pd_n_s, pd_drv_s, lp_s, lp_drv_s, byp_s, seq_s} = pin_s[13:8];
  assign chan_pins = pin_s[7:5];
  assign gain_pins = pin_s[4:2];
  assign csb_s = pin_s[1];
  assign res_s = pin_s[0];

  // Undriven pins resolve to their internal pull
  logic pd_n_eff, lp_eff;
  assign pd_n_eff = pd_drv_s ? pd_n_s : 1'b1; // R7
  assign lp_eff = lp_drv_s ? lp_s : 1'b0; // R11

  // ***************************************************
  // Next-state logic
  // ***************************************************
  adc_ctrl_pkg::pwr_state_t pwr, next_pwr;
  logic [adc_ctrl_pkg::WAKE_W-1:0] wake_cnt, next_wake_cnt;
  logic csb_q, next_csb_q, seq_q, next_seq_q;
  logic seq_armed, next_seq_armed;
  logic [adc_ctrl_pkg::CHAN_W-1:0] seq_chan, next_seq_chan;
  logic [2:0] lat_chan, next_lat_chan, lat_gain, next_lat_gain;
  logic lat_byp, next_lat_byp;
  logic [2:0] app_chan, next_app_chan, app_gain, next_app_gain;
  logic app_byp, next_app_byp;
  logic first_pending, next_first_pending;
  logic [7:0] conv_cnt, next_conv_cnt;
  logic next_busy, next_start, next_abort, next_valid;
  logic next_sdo, next_oe;
  logic [adc_ctrl_pkg::GAIN_W-1:0] dec_gain;
  logic [2:0] chan_src;
  logic csb_rise, csb_fall, running;

  localparam logic [adc_ctrl_pkg::WAKE_W-1:0] WAKE_LAST =
    adc_ctrl_pkg::WAKE_W'(adc_ctrl_pkg::WAKE_CYCLES - 1);
  localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);

  gain_decode u_gain (
    .bypass_i(app_byp),
    .code_i(app_gain),
    .gain_o(dec_gain)
  );

  assign running = (pwr == adc_ctrl_pkg::PWR_RUN);
  assign csb_rise = csb_s & ~csb_q & running; // R21
  assign csb_fall = ~csb_s & csb_q & running; // R21

  always_comb
  begin
    next_pwr = pwr;
    next_wake_cnt = wake_cnt;
    next_csb_q = csb_s;
    next_seq_q = seq_s;
    next_seq_armed = seq_armed;
    next_seq_chan = seq_chan;
    next_lat_chan = lat_chan;
    next_lat_gain = lat_gain;
    next_lat_byp = lat_byp;
    next_app_chan = app_chan;
    next_app_gain = app_gain;
    next_app_byp = app_byp;
    next_first_pending = first_pending;
    next_conv_cnt = conv_cnt;
    next_busy = busy_o;
    next_start = 1'b0;
    next_abort = 1'b0;
    next_valid = sample_valid_o;
    chan_src = chan_pins;
    case (pwr)
      adc_ctrl_pkg::PWR_DOWN:
      begin
        if (pd_n_eff) // R4
        begin
          next_pwr = adc_ctrl_pkg::PWR_WAKE;
          next_wake_cnt = '0;
        end
      end
      adc_ctrl_pkg::PWR_WAKE:
      begin
        if (wake_cnt == WAKE_LAST)
        begin
          next_pwr = adc_ctrl_pkg::PWR_RUN; // R4
        end
        else
        begin
          next_wake_cnt = wake_cnt + 1'b1;
        end
      end
      default:
      begin
      end
    endcase
    // Sequencer restart on each enable rise that does not share its cycle with a convert-start rise
    if (seq_s && !seq_q)
    begin
      next_seq_armed = 1'b0; // R20
    end
    if (csb_rise)
    begin
      if (seq_s) // R12
      begin
        next_seq_chan = seq_armed ? seq_chan + 1'b1 : adc_ctrl_pkg::CHAN_FIRST; // R13 R14
        next_seq_armed = 1'b1;
        chan_src = next_seq_chan; // R15
      end
      next_lat_chan = chan_src; // R16 R19
      next_lat_gain = gain_pins; // R19
      next_lat_byp = byp_s;
    end
    if (csb_fall) // R17
    begin
      next_start = 1'b1;
      next_busy = 1'b1;
      next_conv_cnt = '0;
      if (lp_eff) // R10
      begin
        next_app_chan = lat_chan; // R6
        next_app_gain = lat_gain;
        next_app_byp = lat_byp;
        next_valid = 1'b1; // R6
      end
      else
      begin
        // Normal mode applies the previous sample's selections
        next_app_chan = app_chan; // R5
        next_app_gain = app_gain;
        next_app_byp = app_byp;
        next_valid = ~first_pending; // R5
      end
      next_first_pending = 1'b0;
    end
    // Normal mode applies what the previous rise latched
    if (csb_rise && !lp_eff)
    begin
      next_app_chan = lat_chan; // R5
      next_app_gain = lat_gain;
      next_app_byp = lat_byp; // R8
    end
    if (busy_o && !csb_fall)
    begin
      if (conv_cnt == CONV_LAST)
      begin
        next_busy = 1'b0;
      end
      else
      begin
        next_conv_cnt = conv_cnt + 1'b1;
      end
    end
    if (!pd_n_eff) // R1
    begin
      next_pwr = adc_ctrl_pkg::PWR_DOWN;
      next_abort = busy_o; // R3
      next_busy = 1'b0; // R3
      next_start = 1'b0;
      next_valid = 1'b0;
      next_first_pending = 1'b1;
    end
    next_oe = running && pd_n_eff && !csb_s; // R3 R17
    next_sdo = next_oe & res_s;
  end

  // ***************************************************
  // State registers
  // ***************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      pwr <= adc_ctrl_pkg::PWR_DOWN;
      wake_cnt <= '0;
      csb_q <= 1'b0;
      seq_q <= 1'b0;
      seq_armed <= 1'b0;
      seq_chan <= adc_ctrl_pkg::CHAN_RESET;
      lat_chan <= adc_ctrl_pkg::CHAN_RESET;
      lat_gain <= 3'h0;
      lat_byp <= 1'b0;
      app_chan <= adc_ctrl_pkg::CHAN_RESET;
      app_gain <= 3'h0;
      app_byp <= 1'b0;
      first_pending <= 1'b1;
      conv_cnt <= '0;
      busy_o <= 1'b0;
      conv_start_o <= 1'b0;
      conv_abort_o <= 1'b0;
      sample_valid_o <= 1'b0;
      powered_down_o <= 1'b1;
      ready_o <= 1'b0;
      low_power_mode_o <= 1'b0;
      gain_stage_bypass_o <= 1'b0;
      active_chan_o <= adc_ctrl_pkg::CHAN_RESET;
      active_gain_o <= adc_ctrl_pkg::GAIN_UNITY;
      serial_result_out_o <= 1'b0;
      serial_result_out_oe_o <= 1'b0;
    end
    else
    begin
      pwr <= next_pwr;
      wake_cnt <= next_wake_cnt;
      csb_q <= next_csb_q;
      seq_q <= next_seq_q;
      seq_armed <= next_seq_armed;
      seq_chan <= next_seq_chan;
      lat_chan <= next_lat_chan;
      lat_gain <= next_lat_gain;
      lat_byp <= next_lat_byp;
      app_chan <= next_app_chan;
      app_gain <= next_app_gain;
      app_byp <= next_app_byp;
      first_pending <= next_first_pending;
      conv_cnt <= next_conv_cnt;
      busy_o <= next_busy;
      conv_start_o <= next_start;
      conv_abort_o <= next_abort;
      sample_valid_o <= next_valid;
      powered_down_o <= (next_pwr == adc_ctrl_pkg::PWR_DOWN); // R1
      ready_o <= (next_pwr == adc_ctrl_pkg::PWR_RUN);
      low_power_mode_o <= lp_eff; // R10
      gain_stage_bypass_o <= app_byp; // R8
      active_chan_o <= app_chan;
      active_gain_o <= dec_gain; // R18
      serial_result_out_o <= next_sdo;
      serial_result_out_oe_o <= next_oe;
    end
  end

endmodule // adc_channel_mode_control

// ===== adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // ***************************************************
  // Widths and codes
  // ***************************************************
  localparam int CHAN_W = 3;
  localparam int GAIN_W = 5;
  localparam int WAKE_W = 12;
  localparam logic [CHAN_W-1:0] CHAN_FIRST = 3'h0;
  localparam logic [CHAN_W-1:0] CHAN_LAST = 3'h7;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 3'h0;
  localparam logic [GAIN_W-1:0] GAIN_UNITY = 5'h01;

  // ***************************************************
  // Timing
  // ***************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int WAKE_TIME_NS = 1000;
  localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ***************************************************
  // Power states
  // ***************************************************
  typedef enum logic [1:0] {
    PWR_DOWN = 2'b00,
    PWR_WAKE = 2'b01,
    PWR_RUN = 2'b10
  } pwr_state_t;

endpackage

// ===== pin_sync.sv
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  input wire logic [WIDTH-1:0] reset_val_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_stage2;

  always_comb
  begin
    next_stage1 = async_i;
    next_stage2 = stage1;
  end

  // Reset value comes only from constant ties at the instance
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      stage1 <= reset_val_i;
      stage2 <= reset_val_i;
    end
    else
    begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign sync_o = stage2;

endmodule // pin_sync

// ===== gain_decode.sv
module gain_decode (
  input wire logic bypass_i,
  input wire logic [2:0] code_i,
  output logic [adc_ctrl_pkg::GAIN_W-1:0] gain_o
);

  always_comb
  begin
    if (bypass_i)
    begin
      gain_o = adc_ctrl_pkg::GAIN_UNITY; // R9
    end
    else
    begin
      case (code_i) // R18
        3'h0: gain_o = 5'h01;
        3'h1: gain_o = 5'h02;
        3'h2: gain_o = 5'h03;
        3'h3: gain_o = 5'h04;
        3'h4: gain_o = 5'h06;
        3'h5: gain_o = 5'h08;
        3'h6: gain_o = 5'h0C;
        default: gain_o = 5'h10;
      endcase
    end
  end

endmodule // gain_decode

// ===== adc_ctrl_checker.sv
module adc_ctrl_checker (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic power_down_n_driven_i,
  input wire logic low_power_select_driven_i,
  input wire logic powered_down_o,
  input wire logic ready_o,
  input wire logic low_power_mode_o,
  input wire logic busy_o,
  input wire logic conv_start_o,
  input wire logic conv_abort_o,
  input wire logic [adc_ctrl_pkg::GAIN_W-1:0] active_gain_o,
  input wire logic serial_result_out_o,
  input wire logic serial_result_out_oe_o
);
  // ****************
  // Pin relations
  // ****************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_pd_oe;
    powered_down_o |-> !serial_result_out_oe_o;
  endproperty
  a_pd_oe: assert property (p_pd_oe) else $error("output driven in power-down");
  property p_pd_rdy;
    powered_down_o |-> !ready_o;
  endproperty
  a_pd_rdy: assert property (p_pd_rdy) else $error("ready in power-down");
  property p_pd_start;
    powered_down_o |-> !conv_start_o;
  endproperty
  a_pd_start: assert property (p_pd_start) else $error("start in power-down");
  property p_abort;
    conv_abort_o |=> !busy_o;
  endproperty
  a_abort: assert property (p_abort) else $error("busy after abort");
  property p_start;
    conv_start_o |-> busy_o ##1 !conv_start_o;
  endproperty
  a_start: assert property (p_start) else $error("bad start pulse");
  property p_gain;
    active_gain_o inside {5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10};
  endproperty
  a_gain: assert property (p_gain) else $error("illegal gain");
  property p_oe_zero;
    !serial_result_out_oe_o |-> !serial_result_out_o;
  endproperty
  a_oe_zero: assert property (p_oe_zero) else $error("data while floating");
  property p_pd_pull;
    (!power_down_n_driven_i) [*8] |-> !powered_down_o;
  endproperty
  a_pd_pull: assert property (p_pd_pull) else $error("undriven pin powers down");
  property p_lpm_pull;
    (!low_power_select_driven_i) [*4] |-> !low_power_mode_o;
  endproperty
  a_lpm_pull: assert property (p_lpm_pull) else $error("undriven low-power select");
  c_abort: cover property (conv_abort_o);
  c_lp_start: cover property (conv_start_o && low_power_mode_o);
  c_pull: cover property (ready_o && !power_down_n_driven_i);
endmodule // adc_ctrl_checker
bind adc_channel_mode_control adc_ctrl_checker chk (.sys_clk_i, .rst_n_i, .power_down_n_driven_i,
  .low_power_select_driven_i, .powered_down_o, .ready_o, .low_power_mode_o, .busy_o, .conv_start_o,
  .conv_abort_o, .active_gain_o, .serial_result_out_o, .serial_result_out_oe_o);

// ===== host_model.sv
module host_model #(
  parameter int CONV = 12
) (
  input wire logic clk_i,
  output logic pd_n_o,
  output logic pd_drv_o,
  output logic lpm_o,
  output logic lpm_drv_o,
  output logic byp_o,
  output logic seq_o,
  output logic [2:0] chan_o,
  output logic [2:0] gain_o,
  output logic csb_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Host pin drive
  // ****************
  initial
  begin
    {pd_n_o, pd_drv_o, lpm_o, lpm_drv_o, byp_o, seq_o} = 6'b110100;
    chan_o = 3'h0;
    gain_o = 3'h0;
    csb_o = 1'b0;
  end
  task automatic set_mode(input logic pd, pdd, lp, lpd, bp, sq);
    @(posedge clk_i);
    #5;
    pd_n_o = pdd ? pd : 1'b0; // Undriven pin shows wrong level
    pd_drv_o = pdd;
    lpm_o = lpd ? lp : 1'b1;
    lpm_drv_o = lpd;
    byp_o = bp;
    seq_o = sq;
  endtask
  task automatic start(input logic [2:0] c, g);
    @(posedge clk_i);
    #5;
    chan_o = c;
    gain_o = g;
    csb_o = 1'b1;
    repeat (4) @(posedge clk_i);
    #5;
    csb_o = 1'b0;
  endtask
  task automatic sample(input logic [2:0] c, g);
    start(c, g);
    repeat (CONV + 8) @(posedge clk_i);
  endtask
endmodule // host_model

// ===== adc_channel_mode_control_tb.sv
`define CHK(n, e, a) begin #1; num_checks++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module adc_channel_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i, rst_n_i, rbit;
  logic pd_n, pd_drv, low_power_select, lpm_drv, byp, seq, convert_start_bar;
  logic [2:0] cs, gs;
  logic pd_o, rdy, lpm_o, byp_o, busy, cst, cab, vld, serial_result_out, oe;
  logic [2:0] chan;
  logic [4:0] gain;
  logic [4:0] gtab [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10};
  int err_count, num_checks, starts, aborts, n;
  host_model #(.CONV(12)) host (.clk_i(sys_clk_i), .pd_n_o(pd_n), .pd_drv_o(pd_drv), .lpm_o(low_power_select),
    .lpm_drv_o(lpm_drv), .byp_o(byp), .seq_o(seq), .chan_o(cs), .gain_o(gs), .csb_o(convert_start_bar));
  adc_channel_mode_control #(.CONV_CYCLES(12)) uut (.sys_clk_i, .rst_n_i, .power_down_n_i(pd_n),
    .power_down_n_driven_i(pd_drv), .low_power_select_i(low_power_select), .low_power_select_driven_i(lpm_drv),
    .gain_stage_bypass_i(byp), .seq_enable_i(seq), .chan_sel_msb_i(cs[2]), .chan_sel_mid_i(cs[1]),
    .chan_sel_lsb_i(cs[0]), .gain_sel_msb_i(gs[2]), .gain_sel_mid_i(gs[1]), .gain_sel_lsb_i(gs[0]),
    .convert_start_bar_i(convert_start_bar), .result_bit_i(rbit), .powered_down_o(pd_o), .ready_o(rdy),
    .low_power_mode_o(lpm_o), .gain_stage_bypass_o(byp_o), .busy_o(busy), .conv_start_o(cst),
    .conv_abort_o(cab), .sample_valid_o(vld), .active_chan_o(chan), .active_gain_o(gain),
    .serial_result_out_o(serial_result_out), .serial_result_out_oe_o(oe));
  // ****************
  // Clock and tasks
  // ****************
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i)
  begin
    rbit <= ~rbit;
    starts <= starts + int'(cst);
    aborts <= aborts + int'(cab);
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_ready;
    for (int i = 0; i < 80 && rdy !== 1'b1; i++)
    begin
      @(posedge sys_clk_i);
      #1;
    end
    `CHK("ready", 1'b1, rdy)
    if (rdy !== 1'b1) end_sim();
  endtask
  // ****************
  // Scenarios
  // ****************
  initial
  begin
    {rst_n_i, rbit, err_count, num_checks, starts, aborts} = '0;
    repeat (6) @(posedge sys_clk_i);
    #5 rst_n_i = 1'b1;
    wait_ready();
    for (int i = 0; i < 8; i++)
    begin
      n = starts;
      host.sample(3'(i), 3'(i));
      host.sample(3'(i), 3'(i));
      `CHK("chan", 3'(i), chan)
      `CHK("gain", gtab[i], gain)
      `CHK("oe", 1'b1, oe)
      `CHK("sdo", ~rbit, serial_result_out)
      `CHK("starts", n + 2, starts)
    end
    host.sample(3'h6, 3'h6);
    `CHK("chan", 3'h7, chan)
    host.set_mode(1, 1, 0, 1, 1, 0);
    repeat (2) host.sample(3'h5, 3'h7);
    `CHK("byp", 1'b1, byp_o)
    `CHK("gain", 5'h01, gain)
    host.set_mode(1, 1, 0, 1, 0, 0);
    repeat (2) host.sample(3'h5, 3'h7);
    `CHK("gain", 5'h10, gain)
    for (int r = 0; r < 2; r++)
    begin
      host.set_mode(1, 1, 0, 1, 0, 1);
      host.sample(3'h3, 3'h0);
      for (int k = 0; k < (r == 0 ? 10 : 2); k++)
      begin
        host.sample(3'h3, 3'h0);
        `CHK("seq", 3'(k % 8), chan)
      end
      host.set_mode(1, 1, 0, 1, 0, 0);
      host.sample(3'h3, 3'h0);
    end
    n = aborts;
    host.start(3'h2, 3'h2);
    repeat (2) @(posedge sys_clk_i);
    host.set_mode(0, 1, 0, 1, 0, 0);
    repeat (8) @(posedge sys_clk_i);
    `CHK("abort", n + 1, aborts)
    `CHK("oe", 1'b0, oe)
    `CHK("busy", 1'b0, busy)
    `CHK("pd", 1'b1, pd_o)
    n = starts;
    host.sample(3'h1, 3'h1);
    `CHK("starts", n, starts)
    host.set_mode(1, 1, 0, 1, 0, 0);
    wait_ready();
    host.sample(3'h1, 3'h1);
    `CHK("valid", 1'b0, vld)
    host.sample(3'h1, 3'h1);
    `CHK("valid", 1'b1, vld)
    host.set_mode(0, 1, 1, 1, 0, 0);
    repeat (10) @(posedge sys_clk_i);
    `CHK("lpm", 1'b1, lpm_o)
    host.set_mode(1, 1, 1, 1, 0, 0);
    wait_ready();
    host.sample(3'h4, 3'h3);
    `CHK("valid", 1'b1, vld)
    `CHK("chan", 3'h4, chan)
    `CHK("gain", 5'h04, gain)
    host.set_mode(0, 0, 1, 0, 0, 0);
    repeat (12) @(posedge sys_clk_i);
    `CHK("pd", 1'b0, pd_o)
    `CHK("lpm", 1'b0, lpm_o)
    end_sim();
  end
endmodule // adc_channel_mode_control_tb
